// ==== core/bank_busy_check.sv ====
// Purpose: Tracks each bank's busy state and judges every command as accepted, ignored or illegal.
// Assumes: Command pins come from outside the clock domain and are synchronised here.
// Notes: Idle and active banks accept the usual commands so that busy states can be entered.
module bank_busy_check (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Command pins from the controller
    input wire bank_busy_pkg::cmd_pins_s pins,
    // Additive latency covers the activate delay
    input wire logic al_covers_rcd,
    // Verdict and state
    output bank_busy_pkg::verdict_s verdict_q,
    output logic [bank_busy_pkg::NUM_BANKS-1:0] bank_busy_q
);

    bank_busy_pkg::cmd_pins_s sync1_q;
    bank_busy_pkg::cmd_pins_s sync2_q;
    bank_busy_pkg::bank_state_e state_q [bank_busy_pkg::NUM_BANKS];
    logic [bank_busy_pkg::CNT_W-1:0] cnt_q [bank_busy_pkg::NUM_BANKS];

    // Command decode from sampled strobe levels
    function automatic bank_busy_pkg::cmd_e decode(input bank_busy_pkg::cmd_pins_s p);
        if (p.cs_n) begin
            return bank_busy_pkg::CMD_DESEL;  // [R12]
        end
        case ({p.ras_n, p.cas_n, p.we_n})
            3'h7: return bank_busy_pkg::CMD_NOP;
            3'h5: return bank_busy_pkg::CMD_READ;
            3'h4: return bank_busy_pkg::CMD_WRITE;
            3'h3: return bank_busy_pkg::CMD_ACTIVE;
            3'h2: return bank_busy_pkg::CMD_PRE;
            3'h1: return bank_busy_pkg::CMD_REFRESH;
            default: return bank_busy_pkg::CMD_MODE;
        endcase  // [R12]
    endfunction

    // Column command: read or write, with or without auto precharge
    function automatic logic is_column(input bank_busy_pkg::cmd_e c);
        return (c == bank_busy_pkg::CMD_READ) || (c == bank_busy_pkg::CMD_WRITE);
    endfunction

    // Refresh and mode setting address every bank at once
    function automatic logic all_bank_cmd(input bank_busy_pkg::cmd_e c);
        return (c == bank_busy_pkg::CMD_REFRESH) || (c == bank_busy_pkg::CMD_MODE);
    endfunction

    // Busy means an auto precharge burst or a recovery, activate, precharge or refresh timer is running in the bank
    function automatic logic is_busy(input bank_busy_pkg::bank_state_e s);
        return (s != bank_busy_pkg::ST_IDLE) && (s != bank_busy_pkg::ST_ACTIVE);
    endfunction

    // The whole command word is sampled as one; a controller holds it for a full clock,
    // so both flops always carry a consistent command
    always_ff @(posedge clk) begin
        if (reset) begin
            sync1_q <= '1;
            sync2_q <= '1;
        end else begin
            sync1_q <= pins;
            sync2_q <= sync1_q;
        end
    end

    bank_busy_pkg::cmd_e cmd;
    logic all_idle;
    logic [bank_busy_pkg::NUM_BANKS-1:0] legal;
    logic [bank_busy_pkg::NUM_BANKS-1:0] quiet;

    always_comb begin
        cmd = decode(sync2_q);
        all_idle = 1'b1;
        for (int b = 0; b < bank_busy_pkg::NUM_BANKS; b++) begin
            if (state_q[b] != bank_busy_pkg::ST_IDLE) begin
                all_idle = 1'b0;
            end
        end
    end

    // Per-bank legality; only the addressed bank judges bank commands [R9]
    always_comb begin
        for (int b = 0; b < bank_busy_pkg::NUM_BANKS; b++) begin
            logic hit;
            logic pre_all;
            logic nopish;
            hit = (sync2_q.bank == b[bank_busy_pkg::BANK_W-1:0]);
            pre_all = (cmd == bank_busy_pkg::CMD_PRE) && sync2_q.auto_pre;
            nopish = (cmd == bank_busy_pkg::CMD_DESEL) || (cmd == bank_busy_pkg::CMD_NOP);
            quiet[b] = 1'b1;
            legal[b] = 1'b1;
            // Precharge-all, refresh and mode setting are judged by every bank, so one
            // busy bank is enough to refuse them, except a precharging bank, which allows precharge-all
            if (!nopish && (hit || pre_all || all_bank_cmd(cmd))) begin
                quiet[b] = 1'b0;
                case (state_q[b])
                    bank_busy_pkg::ST_IDLE:
                        legal[b] = (cmd != bank_busy_pkg::CMD_READ)
                                   && (cmd != bank_busy_pkg::CMD_WRITE);
                    bank_busy_pkg::ST_ACTIVE:
                        legal[b] = (cmd == bank_busy_pkg::CMD_READ)
                                   || (cmd == bank_busy_pkg::CMD_WRITE)
                                   || (cmd == bank_busy_pkg::CMD_PRE);
                    bank_busy_pkg::ST_PRECHARGING:
                        legal[b] = (cmd == bank_busy_pkg::CMD_PRE);  // [R4]
                    bank_busy_pkg::ST_ACTIVATING:
                        legal[b] = al_covers_rcd && is_column(cmd);  // [R5] [R10]
                    bank_busy_pkg::ST_WR_RECOVER:
                        legal[b] = (cmd == bank_busy_pkg::CMD_WRITE);  // [R6]
                    default:
                        legal[b] = 1'b0;  // [R3] [R7] [R8]
                endcase
            end
        end
    end

    logic bad;
    always_comb begin
        bad = ~&legal;
        // Refresh and mode setting need every bank idle
        if (all_bank_cmd(cmd) && !all_idle) begin
            bad = 1'b1;
        end
    end

    // A precharge to a bank already precharging is a no-operation: its timer keeps running,
    // or a controller repeating the command could hold the bank busy for ever
    logic [bank_busy_pkg::NUM_BANKS-1:0] takes_cmd;
    always_comb begin
        for (int b = 0; b < bank_busy_pkg::NUM_BANKS; b++) begin
            takes_cmd[b] = !quiet[b] && !bad
                           && (state_q[b] != bank_busy_pkg::ST_PRECHARGING);  // [R4]
        end
    end

    // Verdict and the state change it causes land on the same edge
    always_ff @(posedge clk) begin
        if (reset) begin
            verdict_q <= '0;
        end else begin
            verdict_q.illegal <= bad;  // [R11]
            verdict_q.ignored <= !bad && (&quiet);
            verdict_q.accepted <= !bad && !(&quiet);
            verdict_q.bank <= sync2_q.bank;
        end
    end

    // Bank state machines; an illegal command leaves state untouched
    for (genvar g = 0; g < bank_busy_pkg::NUM_BANKS; g++) begin : g_bank
        always_ff @(posedge clk) begin
            if (reset) begin
                state_q[g] <= bank_busy_pkg::ST_IDLE;
                cnt_q[g] <= bank_busy_pkg::CNT_ZERO;
            end else if (takes_cmd[g]) begin
                case (cmd)
                    bank_busy_pkg::CMD_ACTIVE: begin
                        state_q[g] <= bank_busy_pkg::ST_ACTIVATING;
                        cnt_q[g] <= bank_busy_pkg::RCD_CYC;
                    end
                    bank_busy_pkg::CMD_READ: begin
                        state_q[g] <= sync2_q.auto_pre ? bank_busy_pkg::ST_READ_AP
                                                       : bank_busy_pkg::ST_ACTIVE;
                        cnt_q[g] <= bank_busy_pkg::BURST_CYC;
                    end
                    bank_busy_pkg::CMD_WRITE: begin
                        state_q[g] <= sync2_q.auto_pre ? bank_busy_pkg::ST_WRITE_AP
                                                       : bank_busy_pkg::ST_WR_RECOVER;
                        cnt_q[g] <= sync2_q.auto_pre ? bank_busy_pkg::BURST_CYC
                                                     : bank_busy_pkg::WR_CYC;  // [R6]
                    end
                    bank_busy_pkg::CMD_PRE: begin
                        // An idle bank stays idle; only an active bank starts precharging
                        if (state_q[g] != bank_busy_pkg::ST_IDLE) begin
                            state_q[g] <= bank_busy_pkg::ST_PRECHARGING;
                            cnt_q[g] <= bank_busy_pkg::RP_CYC;  // [R4]
                        end
                    end
                    bank_busy_pkg::CMD_REFRESH: begin
                        state_q[g] <= bank_busy_pkg::ST_REFRESHING;
                        cnt_q[g] <= bank_busy_pkg::RFC_CYC;
                    end
                    default: begin
                    end
                endcase
            end else if (cnt_q[g] > bank_busy_pkg::CNT_ONE) begin
                // Timers run on cycles that bring this bank no accepted command, or a precharge while it is precharging
                cnt_q[g] <= cnt_q[g] - bank_busy_pkg::CNT_ONE;  // [R1] [R2]
            end else if (cnt_q[g] == bank_busy_pkg::CNT_ONE) begin
                cnt_q[g] <= bank_busy_pkg::CNT_ZERO;
                case (state_q[g])
                    bank_busy_pkg::ST_READ_AP: begin
                        state_q[g] <= bank_busy_pkg::ST_PRECHARGING;
                        cnt_q[g] <= bank_busy_pkg::RP_CYC;  // [R1]
                    end
                    bank_busy_pkg::ST_WRITE_AP: begin
                        state_q[g] <= bank_busy_pkg::ST_WR_RECOVER_AP;
                        cnt_q[g] <= bank_busy_pkg::WR_CYC;  // [R2]
                    end
                    bank_busy_pkg::ST_WR_RECOVER_AP: begin
                        state_q[g] <= bank_busy_pkg::ST_PRECHARGING;
                        cnt_q[g] <= bank_busy_pkg::RP_CYC;  // [R7]
                    end
                    bank_busy_pkg::ST_PRECHARGING:
                        state_q[g] <= bank_busy_pkg::ST_IDLE;  // [R4]
                    bank_busy_pkg::ST_REFRESHING:
                        state_q[g] <= bank_busy_pkg::ST_IDLE;  // [R8]
                    bank_busy_pkg::ST_ACTIVATING,
                    bank_busy_pkg::ST_WR_RECOVER:
                        state_q[g] <= bank_busy_pkg::ST_ACTIVE;  // [R5] [R6]
                    default: begin
                    end
                endcase
            end
        end

        always_ff @(posedge clk) begin
            if (reset) begin
                bank_busy_q[g] <= 1'b0;
            end else begin
                bank_busy_q[g] <= is_busy(state_q[g]);
            end
        end
    end

endmodule  // bank_busy_check

// ==== core/bank_busy_pkg.sv ====
// Purpose: Constants, types and command codes for the per-bank busy-state command checker.
// Assumes: Commands are sampled on the rising edge of clk, one per cycle, with a 2-bit bank address.
// Notes: Minimum times are rounded up to whole clock cycles.
// Functional notes
// R1: A deselect or no-operation during a read burst with auto precharge lets the burst run to its end.
// R2: A deselect or no-operation during a write burst with auto precharge lets the burst complete.
// R3: The controller sends no column, row, precharge, refresh or mode command to a bank bursting with auto precharge.
// R4: While precharging, deselect, no-operation and precharge are no-operations, and the bank idles after the precharge time.
// R5: While activating, deselect and no-operation are ignored, the bank goes active after the activate delay, and all else except an R10 read or write is illegal.
// R6: Write recovery without auto precharge ends in bank active, accepts a new write, and rejects the other commands.
// R7: Write recovery with auto precharge accepts only deselect or no-operation until the recovery time ends.
// R8: During refresh, deselect and no-operation are no-operations, idle follows the refresh time, and no read or write may come first.
// R9: A command that is illegal only for one busy bank may still go to another bank whose state allows it.
// R10: A read or write to an activating row is allowed only when the additive latency covers the activate delay.
// R11: Every illegal command is flagged as a protocol violation.
// R12: Commands decode from chip select and the three strobes; a high chip select means deselect.
package bank_busy_pkg;

    localparam int NUM_BANKS = 4;
    localparam int BANK_W = 2;
    localparam int CNT_W = 8;
    localparam int CLK_PERIOD_NS = 10;

    // Minimum times in ns; counts round up to whole cycles
    localparam int T_RP_NS = 15;
    localparam int T_RCD_NS = 15;
    localparam int T_WR_NS = 15;
    localparam int T_RFC_NS = 105;
    localparam int BURST_CYCLES = 4;

    function automatic logic [CNT_W-1:0] ns_to_cycles(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        if (c < 1) begin
            c = 1;
        end
        return c[CNT_W-1:0];
    endfunction

    localparam logic [CNT_W-1:0] RP_CYC = ns_to_cycles(T_RP_NS);
    localparam logic [CNT_W-1:0] RCD_CYC = ns_to_cycles(T_RCD_NS);
    localparam logic [CNT_W-1:0] WR_CYC = ns_to_cycles(T_WR_NS);
    localparam logic [CNT_W-1:0] RFC_CYC = ns_to_cycles(T_RFC_NS);
    localparam logic [CNT_W-1:0] BURST_CYC = BURST_CYCLES[CNT_W-1:0];
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ACTIVE = 4'h1,
        ST_READ_AP = 4'h2,
        ST_WRITE_AP = 4'h3,
        ST_PRECHARGING = 4'h4,
        ST_ACTIVATING = 4'h5,
        ST_WR_RECOVER = 4'h6,
        ST_WR_RECOVER_AP = 4'h7,
        ST_REFRESHING = 4'h8
    } bank_state_e;

    typedef enum logic [2:0] {
        CMD_DESEL = 3'h0,
        CMD_NOP = 3'h1,
        CMD_READ = 3'h2,
        CMD_WRITE = 3'h3,
        CMD_ACTIVE = 3'h4,
        CMD_PRE = 3'h5,
        CMD_REFRESH = 3'h6,
        CMD_MODE = 3'h7
    } cmd_e;

    // Raw command pins, chip select and strobes active low as on the bus
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [BANK_W-1:0] bank;
        logic auto_pre;
    } cmd_pins_s;

    typedef struct packed {
        logic illegal;
        logic ignored;
        logic accepted;
        logic [BANK_W-1:0] bank;
    } verdict_s;

endpackage

// ==== testbench/cmd_ctrl_model.sv ====
// Purpose: Controller model driving command pins from bench requests.
// Assumes: Requests change just after a falling edge.
// Notes: Strobes toggle while deselected, so no stale level is trusted.
module cmd_ctrl_model (
    // Clock
    input wire logic clk,
    // Request
    input wire bank_busy_pkg::cmd_e cmd,
    input wire logic [1:0] bank,
    input wire logic auto_pre,
    // Pins
    output bank_busy_pkg::cmd_pins_s pins
);
    timeunit 1ns;
    timeprecision 1ps;
    logic noise_q = 1'b0;
    logic [2:0] rcw;
    always_ff @(negedge clk) begin
        noise_q <= ~noise_q;
    end
    // Obeys the bench blindly, so illegal orders are deliberate
    always_comb begin
        case (cmd)
            bank_busy_pkg::CMD_DESEL: rcw = {3{noise_q}};
            bank_busy_pkg::CMD_NOP: rcw = 3'h7;
            default: rcw = 3'h7 - cmd;
        endcase
    end
    assign pins = {cmd == bank_busy_pkg::CMD_DESEL, rcw, bank, auto_pre};
endmodule // cmd_ctrl_model

// ==== testbench/bank_busy_sva.sv ====
// Purpose: Assertions on verdict and busy outputs.
// Assumes: A verdict trails its pins by three clocks.
// Notes: Idle until the pin copy has filled after reset.
module bank_busy_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Inputs
    input wire bank_busy_pkg::cmd_pins_s pins,
    input wire logic al_covers_rcd,
    // Outputs
    input wire bank_busy_pkg::verdict_s verdict_q,
    input wire logic [bank_busy_pkg::NUM_BANKS-1:0] bank_busy_q
);
    timeunit 1ns;
    timeprecision 1ps;
    bank_busy_pkg::cmd_pins_s p1_q, p2_q, p3_q;
    logic [2:0] settle_q;
    logic [2:0] code;
    logic [2:0] rcw;
    logic sel;
    always_ff @(posedge clk) begin
        p1_q <= pins;
        p2_q <= p1_q;
        p3_q <= p2_q;
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            settle_q <= 3'h0;
        end else if (settle_q != 3'h4) begin
            settle_q <= settle_q + 3'h1;
        end
    end
    assign code = {verdict_q.illegal, verdict_q.ignored, verdict_q.accepted};
    assign rcw = {p3_q.ras_n, p3_q.cas_n, p3_q.we_n};
    assign sel = settle_q == 3'h4 && !p3_q.cs_n;
    default clocking dc @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_act_ok;
        sel && rcw == 3'h3 && verdict_q.accepted;
    endsequence
    sequence s_burst_ap_ok;
        sel && rcw[2:1] == 2'h2 && p3_q.auto_pre && verdict_q.accepted;
    endsequence
    // One instance per bank keeps overlapping spans on different banks apart
    property p_span_act(i);
        (s_act_ok ##0 verdict_q.bank == 2'(i)) |=> bank_busy_q[i] ##[1:6] !bank_busy_q[i];
    endproperty
    property p_span_burst(i);
        (s_burst_ap_ok ##0 verdict_q.bank == 2'(i))
            |=> bank_busy_q[i] [*4] ##[1:12] !bank_busy_q[i];
    endproperty
    a_one_verdict: assert property (settle_q == 3'h4 |-> $onehot(code))
        else $error("verdict not one-hot");
    a_desel_ignored: assert property (settle_q == 3'h4 && p3_q.cs_n |-> code == 3'h2)
        else $error("deselect not ignored");
    a_nop_ignored: assert property (sel && rcw == 3'h7 |-> code == 3'h2)
        else $error("nop not ignored");
    a_busy_read: assert property (sel && rcw == 3'h5 && bank_busy_q[p3_q.bank]
        && !$past(al_covers_rcd) |-> code == 3'h4) else $error("read to busy bank passed");
    a_busy_active: assert property (sel && rcw == 3'h3 && bank_busy_q[p3_q.bank]
        |-> code == 3'h4) else $error("activate to busy bank passed");
    a_refresh_span: assert property (sel && rcw == 3'h1 && verdict_q.accepted
        |=> (bank_busy_q == '1) [*8] ##[1:12] bank_busy_q == '0) else $error("refresh span");
    for (genvar i = 0; i < bank_busy_pkg::NUM_BANKS; i++) begin : g_span
        a_act_span: assert property (p_span_act(i))
            else $error("activate span wrong");
        a_burst_span: assert property (p_span_burst(i))
            else $error("auto precharge burst span wrong");
    end
endmodule // bank_busy_sva

// ==== testbench/tb.sv ====
// Purpose: Self-checking bench for the bank busy checker.
// Assumes: A verdict is read at the third falling edge after its command.
// Notes: Expectation 0 takes any legal verdict where the state may just have moved.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [2:0] IL = 3'h4;
    localparam logic [2:0] IG = 3'h2;
    localparam logic [2:0] AC = 3'h1;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic al_covers_rcd = 1'b0;
    bank_busy_pkg::cmd_e cmd = bank_busy_pkg::CMD_DESEL;
    logic [1:0] bank = 2'h0;
    logic ap = 1'b0;
    logic [7:0] lfsr = 8'h5E;
    logic [1:0] b;
    logic [2:0] expq[$];
    logic [1:0] bkq[$];
    int err_total = 0;
    int checks = 0;
    bank_busy_pkg::cmd_pins_s pins;
    bank_busy_pkg::verdict_s verdict_q;
    logic [3:0] bank_busy_q;
    always #5 clk = ~clk;
    cmd_ctrl_model u_ctrl (.clk(clk), .cmd(cmd), .bank(bank), .auto_pre(ap), .pins(pins));
    bank_busy_check u_dut (.clk(clk), .reset(reset), .pins(pins), .al_covers_rcd(al_covers_rcd),
        .verdict_q(verdict_q), .bank_busy_q(bank_busy_q));
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // A zero expectation only forbids the illegal flag
    function automatic logic [2:0] expect_of(input logic [2:0] got, input logic [2:0] e);
        return (e == 3'h0) ? {got[2], 2'h0} : got;
    endfunction
    task automatic cmp_word(input logic [3:0] got, input logic [3:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp_verdict(input logic [2:0] got, input logic [2:0] e);
        cmp_word({1'b0, expect_of(got, e)}, {1'b0, e});
    endtask
    task automatic cmp_bank(input logic [1:0] got, input logic [1:0] exp);
        cmp_word({2'h0, got}, {2'h0, exp});
    endtask
    task automatic step(input logic [2:0] c, input logic [1:0] bk, input logic [2:0] e,
            input logic a = 1'b0);
        @(negedge clk);
        if (expq.size() == 3) begin
            cmp_verdict(verdict_q[4:2], expq.pop_front());
            cmp_bank(verdict_q.bank, bkq.pop_front());
        end
        expq.push_back(e);
        bkq.push_back(bk);
        cmd = bank_busy_pkg::cmd_e'(c);
        bank = bk;
        ap = a;
    endtask
    task automatic fill(input int n);
        repeat (n) begin
            lfsr = lfsr_next(lfsr);
            step({2'h0, lfsr[0]}, lfsr[2:1], IG, lfsr[3]);
        end
    endtask
    task automatic tally_and_finish();
        if (err_total == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #20us;
        err_total++;
        tally_and_finish();
    end
    initial begin
        repeat (10) @(negedge clk);
        reset = 1'b0;
        lfsr = lfsr_next(lfsr);
        b = lfsr[1:0];
        fill(3);
        step(3'h4, b, AC);
        step(3'h2, b, IL);
        step(3'h5, b, IL);
        step(3'h4, b + 2'h1, AC);
        fill(5);
        step(3'h3, b, AC, 1'b1);
        step(3'h1, b, IG);
        step(3'h2, b, IL);
        step(3'h6, b, IL);
        fill(1);
        step(3'h3, b, IL);
        fill(10);
        step(3'h2, b + 2'h1, AC, 1'b1);
        step(3'h0, b + 2'h1, IG);
        step(3'h7, b + 2'h1, IL);
        fill(10);
        step(3'h4, b, AC);
        fill(4);
        step(3'h3, b, AC);
        step(3'h2, b, IL);
        step(3'h3, b, AC);
        step(3'h4, b, IL);
        fill(2);
        step(3'h3, b, AC);
        fill(10);
        step(3'h5, b, AC);
        step(3'h4, b, IL);
        step(3'h5, b, AC);
        fill(4);
        step(3'h6, b, AC);
        step(3'h1, b, IG);
        step(3'h3, b + 2'h1, IL);
        fill(3);
        cmp_word(bank_busy_q, 4'hF);
        fill(14);
        cmp_word(bank_busy_q, 4'h0);
        step(3'h4, b, AC);
        al_covers_rcd = 1'b1;
        step(3'h2, b, AC);
        fill(3);
        al_covers_rcd = 1'b0;
        fill(3);
        tally_and_finish();
    end
endmodule // tb
bind bank_busy_check bank_busy_sva u_sva (.clk(clk), .reset(reset), .pins(pins),
    .al_covers_rcd(al_covers_rcd), .verdict_q(verdict_q), .bank_busy_q(bank_busy_q));
